// >>> verilog/timer_channel_mode_control.sv
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
// One timer channel: mode decode, event flag, pin control, APB access
module timer_channel_mode_control (
  input wire logic ref_clk, // 50 MHz system clock
  input wire logic reset_n, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic counterMatch, // Counter equals channel value
  input wire logic counterWrap, // Counter restarts a period
  input wire logic countingUp, // Counter direction, high for up
  input wire logic dutyExtreme, // Duty programmed to 0% or 100%
  input wire logic channelPinIn, // Channel pin level
  output logic channelPinOut, // Channel pin drive value
  output logic channelPinOe_n, // Pin drive enable, low drives
  output logic centerAligned, // Counter runs up/down
  output logic valueLatchReset, // Restart value coherency latch
  output logic channelIrq, // Channel request, flag and enable
  output logic irq // Masked summary interrupt
);
  import tcmc_pkg::*;

  // Register state
  logic [7:0] mainCtrl_q;
  logic eventFlag_q;
  logic eventFlag_d;
  logic irqEnable_q;
  logic [3:0] modeField_q;
  logic clearArmed_q;
  logic clearArmed_d;
  logic [1:0] intStatus_q;
  logic [1:0] intStatus_d;
  logic [1:0] intMask_q;
  logic pinOut_q;
  logic pinOut_d;
  logic latchReset_q;

  // APB handshake state
  logic ready_q;
  logic [31:0] rdata_q;
  logic slverr_q;

  // Returns the channel mode from the center select and mode bits
  function automatic tcmc_mode_e decodeMode(input logic center, input logic msb,
                                            input logic msa);
    tcmc_mode_e m;
    m = TCMC_MODE_CAPTURE;
    if (center) begin
      m = TCMC_MODE_CENTER_PWM;
    end else if (msb) begin
      m = TCMC_MODE_EDGE_PWM;
    end else if (msa) begin
      m = TCMC_MODE_COMPARE;
    end else begin
      m = TCMC_MODE_CAPTURE;
    end
    return m;
  endfunction : decodeMode

  // Pin level applied on a compare match for the given edge/level code
  function automatic logic compareLevel(input logic [1:0] el, input logic current);
    logic lvl;
    lvl = current;
    unique case (el)
      TCMC_EL_01: lvl = ~current;
      TCMC_EL_10: lvl = 1'b0;
      TCMC_EL_11: lvl = 1'b1;
      TCMC_EL_OFF: lvl = current;
    endcase
    return lvl;
  endfunction : compareLevel

  // Address decode
  wire apbAccess = psel & penable;
  wire apbDone = apbAccess & ready_q;
  wire apbWrite = apbDone & pwrite;
  wire apbRead = apbDone & ~pwrite;
  wire hitMain = (paddr == TCMC_OFS_MAIN);
  wire hitChan = (paddr == TCMC_OFS_CHAN);
  wire hitStat = (paddr == TCMC_OFS_STAT);
  wire hitMask = (paddr == TCMC_OFS_MASK);
  wire hitAny = hitMain | hitChan | hitStat | hitMask;
  wire wrMain = apbWrite & hitMain;
  wire wrChan = apbWrite & hitChan;
  wire wrStat = apbWrite & hitStat;
  wire wrMask = apbWrite & hitMask;
  wire rdChan = apbRead & hitChan;

  // Mode and field decode
  wire centerSel = mainCtrl_q[TCMC_MAIN_CENTER_BIT];
  wire [1:0] edgeLevel = modeField_q[1:0];
  wire pinReleased = (edgeLevel == TCMC_EL_OFF);
  tcmc_mode_e chanMode;
  assign chanMode = decodeMode(centerSel, modeField_q[3], modeField_q[2]);
  wire inCapture = (chanMode == TCMC_MODE_CAPTURE);
  wire inCompare = (chanMode == TCMC_MODE_COMPARE);
  wire inEdgePwm = (chanMode == TCMC_MODE_EDGE_PWM);
  wire inCenterPwm = (chanMode == TCMC_MODE_CENTER_PWM);
  wire inPwm = inEdgePwm | inCenterPwm;
  // Field 10 means high-true pulses, any value ending in 1 low-true
  wire lowTrue = edgeLevel[0];

  // Capture edge from the pin; the pin is taken as synchronous already
  wire captureEdge;
  tcmc_edge_detect u_edge (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pinIn(channelPinIn),
    .edgeSel(edgeLevel),
    .enable(inCapture & ~pinReleased),
    .edgeSeen(captureEdge)
  );

  // Channel events by mode; extreme duty suppresses the PWM flag
  wire compareEvent = counterMatch & inCompare;
  wire pwmEvent = counterMatch & inPwm & ~dutyExtreme;
  wire channelEvent = captureEdge | compareEvent | pwmEvent;

  // Clear sequence: the read arms it, a zero write finishes it
  wire writeFlagZero = wrChan & ~pwdata[TCMC_CH_FLAG_BIT];
  wire clearComplete = writeFlagZero & clearArmed_q & ~channelEvent;

  always_comb begin
    eventFlag_d = eventFlag_q;
    clearArmed_d = clearArmed_q;
    if (channelEvent) begin
      // New event restarts the sequence so no request is lost
      eventFlag_d = 1'b1;
      clearArmed_d = 1'b0;
    end else if (clearComplete) begin
      eventFlag_d = 1'b0;
      clearArmed_d = 1'b0;
    end else if (rdChan & eventFlag_q) begin
      clearArmed_d = 1'b1;
    end else if (writeFlagZero) begin
      // A zero write without the read only drops the arming
      clearArmed_d = 1'b0;
    end
  end

  // Flag and arming state; writing one to the flag is ignored
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      eventFlag_q <= TCMC_CHAN_RESET[TCMC_CH_FLAG_BIT];
      clearArmed_q <= 1'b0;
    end else begin
      eventFlag_q <= eventFlag_d;
      clearArmed_q <= clearArmed_d;
    end
  end

  // Channel control bits below the flag
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqEnable_q <= TCMC_CHAN_RESET[TCMC_CH_IE_BIT];
      modeField_q <= TCMC_CHAN_RESET[TCMC_CH_MSB_BIT:TCMC_CH_ELA_BIT];
    end else if (wrChan) begin
      irqEnable_q <= pwdata[TCMC_CH_IE_BIT];
      modeField_q <= pwdata[TCMC_CH_MSB_BIT:TCMC_CH_ELA_BIT];
    end
  end

  // Main control; only the center select is implemented, others read zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mainCtrl_q <= TCMC_MAIN_RESET;
    end else if (wrMain) begin
      mainCtrl_q <= 8'h00;
      mainCtrl_q[TCMC_MAIN_CENTER_BIT] <= pwdata[TCMC_MAIN_CENTER_BIT];
    end
  end

  // Any channel control write restarts the value latch, debug or not
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      latchReset_q <= 1'b0;
    end else begin
      latchReset_q <= wrChan;
    end
  end

  // Pin output: compare actions and PWM set/clear points
  always_comb begin
    pinOut_d = pinOut_q;
    if (inCompare & counterMatch) begin
      pinOut_d = compareLevel(edgeLevel, pinOut_q);
    end else if (inEdgePwm) begin
      if (counterMatch) begin
        pinOut_d = lowTrue;
      end else if (counterWrap) begin
        pinOut_d = ~lowTrue;
      end
    end else if (inCenterPwm & counterMatch) begin
      // Up-count match ends the active phase, down-count match starts it
      pinOut_d = countingUp ? lowTrue : ~lowTrue;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinOut_q <= 1'b0;
    end else if (pinReleased) begin
      pinOut_q <= 1'b0;
    end else begin
      pinOut_q <= pinOut_d;
    end
  end

  // Interrupt status: hardware set beats a same-cycle software clear
  always_comb begin
    intStatus_d = intStatus_q;
    if (wrStat) begin
      intStatus_d = intStatus_q & ~pwdata[1:0];
    end
    if (channelEvent) begin
      intStatus_d[TCMC_ST_EVENT_BIT] = 1'b1;
    end
    if (inCompare & counterMatch & ~pinReleased) begin
      intStatus_d[TCMC_ST_ACTION_BIT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      intStatus_q <= TCMC_STAT_RESET;
      intMask_q <= TCMC_MASK_RESET;
    end else begin
      intStatus_q <= intStatus_d;
      if (wrMask) begin
        intMask_q <= pwdata[1:0];
      end
    end
  end

  // Read data mux
  wire [7:0] chanRead = {eventFlag_q, irqEnable_q, modeField_q, 2'b00};
  wire [31:0] readMux = hitMain ? {24'h000000, mainCtrl_q} :
                        hitChan ? {24'h000000, chanRead} :
                        hitStat ? {30'h00000000, intStatus_q} :
                        hitMask ? {30'h00000000, intMask_q} : 32'h00000000;

  // APB slave: one wait state so read data and error come from flops.
  // The extra cycle per access is traded for a clean registered read path;
  // the master must wait on pready and never count cycles itself.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_q <= 1'b0;
      rdata_q <= 32'h00000000;
      slverr_q <= 1'b0;
    end else begin
      ready_q <= apbAccess & ~ready_q;
      if (apbAccess & ~ready_q) begin
        rdata_q <= pwrite ? 32'h00000000 : readMux;
        slverr_q <= ~hitAny;
      end
    end
  end

  // Outputs
  assign pready = ready_q;
  assign prdata = rdata_q;
  assign pslverr = slverr_q;
  assign centerAligned = centerSel;
  assign valueLatchReset = latchReset_q;
  // Capture mode only listens; released pin is handed back
  assign channelPinOe_n = pinReleased | inCapture;
  assign channelPinOut = pinOut_q;
  assign channelIrq = eventFlag_q & irqEnable_q;
  assign irq = |(intStatus_q & intMask_q);

endmodule : timer_channel_mode_control

// >>> verilog/tcmc_pkg.sv
// Contract
// - Capture mode: active pin edge sets flag
// - Compare/PWM modes: counter match sets flag
// - PWM at 0% or 100% never sets flag
// - Interrupt while flag and enable both set
// - Enable bit read/write, reset clears it
// - Clear flag: read while set, write 0
// - New event during clear keeps flag set
// - Reset clears flag; writing 1 ignored
// - Mode bit B selects edge PWM
// - Mode bit A: capture or compare
// - Edge/level 00 releases the pin
// - Capture edges: rising, falling, either
// - Compare match: toggle, clear, set pin
// - Edge PWM polarity from edge/level field
// - Center select forces center PWM everywhere
// - Center select makes counter up/down; reset clears
// - Control write resets value coherency latch
package tcmc_pkg;

  // Register byte offsets
  localparam logic [7:0] TCMC_OFS_MAIN = 8'h00;
  localparam logic [7:0] TCMC_OFS_CHAN = 8'h04;
  localparam logic [7:0] TCMC_OFS_STAT = 8'h08;
  localparam logic [7:0] TCMC_OFS_MASK = 8'h0C;

  // Main control field
  localparam int TCMC_MAIN_CENTER_BIT = 5;

  // Channel control fields
  localparam int TCMC_CH_FLAG_BIT = 7;
  localparam int TCMC_CH_IE_BIT = 6;
  localparam int TCMC_CH_MSB_BIT = 5;
  localparam int TCMC_CH_MSA_BIT = 4;
  localparam int TCMC_CH_ELB_BIT = 3;
  localparam int TCMC_CH_ELA_BIT = 2;

  // Interrupt status fields
  localparam int TCMC_ST_EVENT_BIT = 0;
  localparam int TCMC_ST_ACTION_BIT = 1;

  // Reset values
  localparam logic [7:0] TCMC_MAIN_RESET = 8'h00;
  localparam logic [7:0] TCMC_CHAN_RESET = 8'h00;
  localparam logic [1:0] TCMC_STAT_RESET = 2'h0;
  localparam logic [1:0] TCMC_MASK_RESET = 2'h0;

  // Pin must be stable this long before entering capture
  localparam int TCMC_PIN_STABLE_CYCLES = 2;

  // Edge/level field codes
  localparam logic [1:0] TCMC_EL_OFF = 2'h0;
  localparam logic [1:0] TCMC_EL_01 = 2'h1;
  localparam logic [1:0] TCMC_EL_10 = 2'h2;
  localparam logic [1:0] TCMC_EL_11 = 2'h3;

  typedef enum logic [1:0] {
    TCMC_MODE_CAPTURE = 2'b00,
    TCMC_MODE_COMPARE = 2'b01,
    TCMC_MODE_EDGE_PWM = 2'b10,
    TCMC_MODE_CENTER_PWM = 2'b11
  } tcmc_mode_e;

endpackage : tcmc_pkg

// >>> verilog/tcmc_edge_detect.sv
`timescale 1ns/10ps
// Detects the selected edge on a pin that is already synchronous
module tcmc_edge_detect (
  input wire logic ref_clk, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic pinIn, // Channel pin level
  input wire logic [1:0] edgeSel, // 01 rise, 10 fall, 11 either
  input wire logic enable, // Capture mode active
  output logic edgeSeen // One-cycle pulse on selected edge
);
  import tcmc_pkg::*;

  logic pinPrev_q;
  wire riseSeen;
  wire fallSeen;

  // History tracks the pin even when idle, so arming capture on a
  // pin that was stable does not fake an edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinPrev_q <= 1'b0;
    end else begin
      pinPrev_q <= pinIn;
    end
  end

  // Edge select decode
  assign riseSeen = pinIn & ~pinPrev_q & edgeSel[0];
  assign fallSeen = ~pinIn & pinPrev_q & edgeSel[1];
  assign edgeSeen = enable & (riseSeen | fallSeen);

endmodule : tcmc_edge_detect

// >>> verification/tcmc_check_sva.sv
`timescale 1ns/10ps
// Port-level checker for one timer channel
module tcmc_check_sva (
  input wire logic ref_clk, // Clock
  input wire logic reset_n, // Reset, low active
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic pready, // Ready
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic counterMatch, // Counter match
  input wire logic counterWrap, // Period restart
  input wire logic countingUp, // Up count
  input wire logic dutyExtreme, // Duty 0 or 100
  input wire logic channelPinOut, // Pin value
  input wire logic channelPinOe_n, // Pin drive, low drives
  input wire logic centerAligned, // Up/down counter
  input wire logic valueLatchReset, // Latch restart
  input wire logic channelIrq // Channel request
);
  import tcmc_pkg::*;
  logic [7:0] chanQ;
  logic cenQ;
  // Accepted writes, decoded once
  wire wrTake = psel && penable && pready && pwrite;
  wire wrChan = wrTake && paddr == TCMC_OFS_CHAN;
  wire [1:0] el = chanQ[3:2];
  wire pwmMode = cenQ || chanQ[5];
  wire cmpHit = !cenQ && chanQ[5:4] == 2'h1 && el != 2'h0 && counterMatch;
  // A wrap in the same cycle loses to the match in the slave, but it is left out all the same
  wire pwmHit = el != 2'h0 && counterMatch && !counterWrap && !dutyExtreme;
  // Shadow of control bits, updated where the slave accepts a write
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      chanQ <= 8'h00;
      cenQ <= 1'b0;
    end else if (wrChan) begin
      chanQ <= pwdata[7:0];
    end else if (wrTake && paddr == TCMC_OFS_MAIN) begin
      cenQ <= pwdata[TCMC_MAIN_CENTER_BIT];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_pin_released: assert property (el == 2'h0 |-> channelPinOe_n)
    else $error("pin driven while released");
  a_irq_enable: assert property (channelIrq |-> chanQ[6])
    else $error("request without enable");
  a_center_select: assert property (centerAligned == cenQ)
    else $error("center select mismatch");
  a_latch_restart: assert property (wrChan |=> valueLatchReset)
    else $error("latch restart missing");
  a_cmp_toggle: assert property (cmpHit && el == 2'h1 |=> $changed(channelPinOut))
    else $error("compare toggle missing");
  a_cmp_level: assert property (cmpHit && el[1] |=> channelPinOut == $past(el[0]))
    else $error("compare level wrong");
  a_edge_pwm: assert property (!cenQ && chanQ[5] && pwmHit |=> channelPinOut == $past(el[0]))
    else $error("edge pwm level wrong");
  a_center_pwm: assert property (cenQ && countingUp && pwmHit |=> channelPinOut == $past(el[0]))
    else $error("center pwm level wrong");
  a_match_flag: assert property ((pwmMode || chanQ[4]) && chanQ[6] && counterMatch
    && !dutyExtreme && !wrChan |=> channelIrq) else $error("match flag missing");
  a_extreme_quiet: assert property (pwmMode && chanQ[6] && dutyExtreme && counterMatch
    && !channelIrq && !wrChan |=> !channelIrq) else $error("flag at extreme duty");
  c_chan_write: cover property (wrChan);
  c_match_irq: cover property (counterMatch ##2 channelIrq);
  c_center_run: cover property (centerAligned && counterMatch);
endmodule : tcmc_check_sva

bind timer_channel_mode_control tcmc_check_sva u_check (.*);

// >>> verification/tcmc_pin_source.sv
`timescale 1ns/10ps
// Outside source and load on the channel pin
module tcmc_pin_source (
  input wire logic ref_clk, // Clock
  input wire logic wantLevel, // Level the source presents
  input wire logic drvOut, // Value the channel drives
  input wire logic drvOe_n, // Channel drive, low drives
  output logic pinWire // Resolved pin level
);
  logic srcQ = 1'b0;
  // Changes only at an edge and then holds, so capture sees no stale edge
  always @(posedge ref_clk) begin
    srcQ <= wantLevel;
  end
  // The channel wins while it drives the pin
  assign pinWire = drvOe_n ? srcQ : drvOut;
endmodule : tcmc_pin_source

// >>> verification/timer_channel_mode_control_test.sv
`timescale 1ns/10ps
module timer_channel_mode_control_test;
  import tcmc_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic counterMatch = 1'b0;
  logic counterWrap = 1'b0;
  logic countingUp = 1'b0;
  logic dutyExtreme = 1'b0;
  logic wantLevel = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, channelPinIn, channelPinOut, channelPinOe_n;
  logic centerAligned, valueLatchReset, channelIrq, irq;
  int failCount = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  logic pinExp;
  logic [1:0] els [4] = '{2'h3, 2'h1, 2'h2, 2'h1};
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  timer_channel_mode_control dut (.*);
  tcmc_pin_source u_source (.ref_clk(ref_clk), .wantLevel(wantLevel),
    .drvOut(channelPinOut), .drvOe_n(channelPinOe_n), .pinWire(channelPinIn));
  task automatic tallyAndFinish();
    $display("Checks %0d, mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tallyAndFinish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failCount++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One-cycle match or wrap, then time for pin and flag to land
  task automatic hit(input logic wrap);
    @(posedge ref_clk);
    if (wrap) counterWrap <= 1'b1;
    else counterMatch <= 1'b1;
    @(posedge ref_clk);
    counterMatch <= 1'b0;
    counterWrap <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : hit
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      failCount++;
      tallyAndFinish();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    apb(0, TCMC_OFS_CHAN, 0);
    chk("chan reset", 0, rd);
    apb(0, TCMC_OFS_MAIN, 0);
    chk("main reset", 0, rd);
    chk("pin released", 1, channelPinOe_n);
    apb(0, 8'h10, 0);
    chk("unmapped", 1, err);
    // Capture on each edge choice; the pin was stable long before
    for (int e = 1; e < 4; e++) begin
      apb(1, TCMC_OFS_CHAN, {24'h0, 4'h4, e[1:0], 2'h0});
      wantLevel <= 1'b1;
      repeat (4) @(posedge ref_clk);
      apb(0, TCMC_OFS_CHAN, 0);
      chk("rise", {24'h0, e[0], 3'h4, e[1:0], 2'h0}, rd);
      chk("rise irq", e[0], channelIrq);
      apb(1, TCMC_OFS_CHAN, {24'h0, 4'h4, e[1:0], 2'h0});
      wantLevel <= 1'b0;
      repeat (4) @(posedge ref_clk);
      apb(0, TCMC_OFS_CHAN, 0);
      chk("fall", {24'h0, e[1], 3'h4, e[1:0], 2'h0}, rd);
      apb(1, TCMC_OFS_CHAN, {24'h0, 4'h4, e[1:0], 2'h0});
    end
    // Compare actions and the clear handshake
    pinExp = 1'b0;
    for (int i = 0; i < 4; i++) begin
      apb(1, TCMC_OFS_CHAN, {24'h0, i[0], 3'h5, els[i], 2'h0});
      hit(0);
      pinExp = els[i] == 2'h1 ? !pinExp : els[i][0];
      chk("compare pin", pinExp, channelPinOut);
      chk("compare irq", 1, channelIrq);
      apb(0, TCMC_OFS_CHAN, 0);
      if (i == 2) hit(0);
      apb(1, TCMC_OFS_CHAN, {24'h0, 4'h5, els[i], 2'h0});
      @(posedge ref_clk);
      chk("clear", i == 2, channelIrq);
    end
    chk("irq masked", 0, irq);
    apb(1, TCMC_OFS_MASK, 1);
    @(posedge ref_clk);
    chk("irq unmasked", 1, irq);
    apb(1, TCMC_OFS_MASK, 2);
    @(posedge ref_clk);
    chk("irq action", 1, irq);
    apb(1, TCMC_OFS_STAT, 3);
    @(posedge ref_clk);
    chk("irq status clear", 0, irq);
    // Edge-aligned polarity, mode bit A varied
    for (int i = 0; i < 3; i++) begin
      apb(1, TCMC_OFS_CHAN, {24'h0, 2'h0, 1'b1, i[0], els[i], 2'h0});
      hit(0);
      chk("edge match", els[i][0], channelPinOut);
      hit(1);
      chk("edge wrap", !els[i][0], channelPinOut);
    end
    apb(0, TCMC_OFS_CHAN, 0);
    chk("pwm flag", 32'hA8, rd);
    apb(1, TCMC_OFS_CHAN, 32'h68);
    dutyExtreme <= 1'b1;
    hit(0);
    chk("extreme", 0, channelIrq);
    dutyExtreme <= 1'b0;
    hit(0);
    chk("edge flag", 1, channelIrq);
    // Center-aligned overrides the mode bits
    apb(1, TCMC_OFS_MAIN, 32'h20);
    @(posedge ref_clk);
    chk("center", 1, centerAligned);
    for (int i = 1; i < 3; i++) begin
      apb(1, TCMC_OFS_CHAN, {24'h0, 4'h0, i[1:0], 2'h0});
      countingUp <= 1'b1;
      hit(0);
      chk("center up", i[0], channelPinOut);
      countingUp <= 1'b0;
      hit(0);
      chk("center down", !i[0], channelPinOut);
    end
    apb(1, TCMC_OFS_CHAN, 0);
    @(posedge ref_clk);
    chk("release", 1, channelPinOe_n);
    tallyAndFinish();
  end
endmodule : timer_channel_mode_control_test
